// ==== design/dpsm_pkg.sv ====
// Shared constants for the per-path data path sequencer.
// Assumes an 8-lane module with an 8-bit plain register port.
package dpsm_pkg;

	// Geometry
	localparam int NUM_LANES = 8;
	localparam int NUM_PATHS = 8;
	localparam int PATH_W    = 3;
	localparam int ADDR_W    = 6;
	localparam int DATA_W    = 8;
	localparam int ADV_SLOTS = 15;

	// Path states, one per data path
	typedef enum logic [1:0] {
		path_idle_state     = 2'b00,
		path_starting_state = 2'b01,
		path_live_state     = 2'b10,
		path_stopping_state = 2'b11
	} dpsm_state_t;

	// Register offsets on the plain port
	localparam logic [ADDR_W-1:0] ADDR_POWER_UP   = 6'h00;
	localparam logic [ADDR_W-1:0] ADDR_CTRL       = 6'h01;
	localparam logic [ADDR_W-1:0] ADDR_TX_DISABLE = 6'h02;
	localparam logic [ADDR_W-1:0] ADDR_TX_SQUELCH = 6'h03;
	localparam logic [ADDR_W-1:0] ADDR_RX_DISABLE = 6'h04;
	localparam logic [ADDR_W-1:0] ADDR_RECONFIG   = 6'h05;
	localparam logic [ADDR_W-1:0] ADDR_START_LIM  = 6'h06;
	localparam logic [ADDR_W-1:0] ADDR_STOP_LIM   = 6'h07;
	localparam logic [ADDR_W-1:0] ADDR_CHANGED    = 6'h08;
	localparam logic [ADDR_W-1:0] ADDR_LANE_CFG   = 6'h10;
	localparam logic [ADDR_W-1:0] ADDR_LANE_STATE = 6'h18;
	localparam logic [ADDR_W-1:0] ADDR_ADV_BASE   = 6'h20;

	// Field positions
	localparam int CTRL_FLP_BIT     = 0;
	localparam int CTRL_PASSIVE_BIT = 1;
	localparam int LANE_APP_LSB     = 4;
	localparam int LANE_APP_W       = 4;

	// Reset values and fixed codes
	localparam logic [LANE_APP_W-1:0] APP_DEFAULT  = 4'h1;
	localparam logic [PATH_W-1:0]     PATH_DEFAULT = 3'h0;
	localparam logic [DATA_W-1:0]     ADV_END_CODE = 8'hFF;
	localparam logic [DATA_W-1:0]     LIMIT_RESET  = 8'h01;

	// Codes reported in the per-lane state registers
	localparam logic [3:0] RPT_NONE     = 4'h0;
	localparam logic [3:0] RPT_IDLE     = 4'h1;
	localparam logic [3:0] RPT_STARTING = 4'h2;
	localparam logic [3:0] RPT_LIVE     = 4'h3;
	localparam logic [3:0] RPT_STOPPING = 4'h4;

endpackage

// ==== design/dpsm_sequencer.sv ====
// Data path sequencer: one independent state machine per data path,
// per-lane output quiescence, state reporting and change flags.
// Assumes a synchronous host register port and synchronous hardware
// inputs (module reset, low-power request, per-path done strobes).
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Summary of operation
// - All lanes of a path move together
// - One independent state machine per path
// - Other paths untouched by one path's change
// - Idle waits forever for host; live also leaves on reset or low power
// - Zero limit hides transient state and flag; reset still flags
// - Idle to starting only when all bits set
// - Lane outputs quiet in idle, starting, stopping
// - Starting to live when initialization completes
// - Reset returns starting or live to idle
// - Live outputs follow disable and squelch controls
// - Live stops on bits cleared or low power
// - Stopping to idle on done or reset
// - One state per path, reported per lane
// - Flag set on module-initiated transitions
// - No flag on host-initiated transitions
// - Passive copper reports no state
// - Advertised list ends with all-ones code
// - Lanes default to application select one
// - Flags clear only on host read
// - Transmit enabled together with receive on entry to live
module dpsm_sequencer
	import dpsm_pkg::*;
#(
	parameter int                ADV_COUNT     = 1,
	parameter logic [DATA_W-1:0] ADV_BASE_CODE = 8'h01 // Arbitrary value
) (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// Register port
	input  wire logic [ADDR_W-1:0]    reg_addr,
	input  wire logic [DATA_W-1:0]    reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [DATA_W-1:0]    reg_rdata,
	// Hardware control signals
	input  wire logic                 mod_reset,
	input  wire logic                 low_power_req,
	// Per-path handshake with data path electronics
	input  wire logic [NUM_PATHS-1:0] start_done,
	input  wire logic [NUM_PATHS-1:0] stop_done,
	output logic      [NUM_PATHS-1:0] path_start_go,
	output logic      [NUM_PATHS-1:0] path_stop_go,
	// Per-lane output enables
	output logic      [NUM_LANES-1:0] tx_out_en,
	output logic      [NUM_LANES-1:0] rx_out_en
);

	////////////////////////////////////////////////////////////////////
	// Helpers

	// Report code for a state
	function automatic logic [3:0] rpt_code(input dpsm_state_t st);
		logic [3:0] code;
		code = RPT_IDLE;
		unique case (st)
			path_idle_state:     code = RPT_IDLE;
			path_starting_state: code = RPT_STARTING;
			path_live_state:     code = RPT_LIVE;
			path_stopping_state: code = RPT_STOPPING;
		endcase
		return code;
	endfunction

	// Host interface code of an advertising slot, end marker after list
	function automatic logic [DATA_W-1:0] adv_code(input int slot);
		logic [DATA_W-1:0] code;
		code = ADV_END_CODE;
		if (slot < ADV_COUNT) begin
			code = ADV_BASE_CODE + DATA_W'(slot);
		end
		return code;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Register storage

	logic [NUM_LANES-1:0]  pwr_up_ff;
	logic                  force_lp_ff;
	logic                  passive_ff;
	logic [NUM_LANES-1:0]  tx_dis_ff;
	logic [NUM_LANES-1:0]  tx_sq_ff;
	logic [NUM_LANES-1:0]  rx_dis_ff;
	logic [DATA_W-1:0]     start_lim_ff;
	logic [DATA_W-1:0]     stop_lim_ff;
	logic [NUM_PATHS-1:0]  chg_ff;
	logic [LANE_APP_W-1:0] lane_app_ff  [NUM_LANES];
	logic [PATH_W-1:0]     lane_path_ff [NUM_LANES];
	dpsm_state_t           state_ff     [NUM_PATHS];
	dpsm_state_t           nxt_state    [NUM_PATHS];
	dpsm_state_t           rpt_ff       [NUM_PATHS];
	logic [NUM_PATHS-1:0]  chg_set;
	logic [NUM_PATHS-1:0]  rpt_upd;
	logic [NUM_PATHS-1:0]  pup_all;
	logic [NUM_PATHS-1:0]  reconf_req;
	logic                  chg_rd;
	logic [DATA_W-1:0]     nxt_rdata;

	assign reconf_req = (reg_wr && reg_addr == ADDR_RECONFIG) ?
		reg_wdata : '0;
	assign chg_rd     = reg_rd && reg_addr == ADDR_CHANGED;

	// Control and option registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_up_ff    <= '0;
			force_lp_ff  <= 1'b0;
			passive_ff   <= 1'b0;
			tx_dis_ff    <= '0;
			tx_sq_ff     <= '0;
			rx_dis_ff    <= '0;
			start_lim_ff <= LIMIT_RESET;
			stop_lim_ff  <= LIMIT_RESET;
		end else if (reg_wr) begin
			unique case (reg_addr)
				ADDR_POWER_UP:   pwr_up_ff    <= reg_wdata;
				ADDR_CTRL: begin
					force_lp_ff <= reg_wdata[CTRL_FLP_BIT];
					passive_ff  <= reg_wdata[CTRL_PASSIVE_BIT];
				end
				ADDR_TX_DISABLE: tx_dis_ff    <= reg_wdata;
				ADDR_TX_SQUELCH: tx_sq_ff     <= reg_wdata;
				ADDR_RX_DISABLE: rx_dis_ff    <= reg_wdata;
				ADDR_START_LIM:  start_lim_ff <= reg_wdata;
				ADDR_STOP_LIM:   stop_lim_ff  <= reg_wdata;
				default: ;
			endcase
		end
	end

	// default app select
	// Lane configuration: application select and owning path
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int l = 0; l < NUM_LANES; l++) begin
				lane_app_ff[l]  <= APP_DEFAULT;
				lane_path_ff[l] <= PATH_DEFAULT;
			end
		end else if (reg_wr) begin
			for (int l = 0; l < NUM_LANES; l++) begin
				if (reg_addr == ADDR_LANE_CFG + ADDR_W'(l)) begin
					lane_app_ff[l]  <= reg_wdata[LANE_APP_LSB +: LANE_APP_W];
					lane_path_ff[l] <= reg_wdata[PATH_W-1:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Path state machines

	// group power-up test
	// A path is requested up only when every one of its lanes has its bit
	always_comb begin
		logic [NUM_LANES-1:0] mask;
		mask    = '0;
		pup_all = '0;
		for (int p = 0; p < NUM_PATHS; p++) begin
			for (int l = 0; l < NUM_LANES; l++) begin
				mask[l] = (lane_path_ff[l] == PATH_W'(p));
			end
			pup_all[p] = (mask != '0) && ((pwr_up_ff & mask) == mask);
		end
	end
	// paths kept independent
	// Each path is evaluated on its own inputs only, so no path disturbs
	// another.
	always_comb begin
		for (int p = 0; p < NUM_PATHS; p++) begin
			nxt_state[p] = state_ff[p];
			chg_set[p]   = 1'b0;
			rpt_upd[p]   = 1'b0;
			unique case (state_ff[p])
				path_idle_state: begin
					if (!mod_reset && pup_all[p]) begin
						nxt_state[p] = path_starting_state;
						rpt_upd[p]   = (start_lim_ff != '0);
					end
				end
				path_starting_state: begin
					if (mod_reset) begin
						nxt_state[p] = path_idle_state;
						chg_set[p]   = 1'b1;
						rpt_upd[p]   = 1'b1;
					end else if (start_done[p]) begin
						nxt_state[p] = path_live_state;
						chg_set[p]   = (start_lim_ff != '0);
						rpt_upd[p]   = 1'b1;
					end
				end
				path_live_state: begin
					if (mod_reset) begin
						nxt_state[p] = path_idle_state;
						chg_set[p]   = 1'b1;
						rpt_upd[p]   = 1'b1;
					end else if (!pup_all[p] || force_lp_ff || low_power_req) begin
						nxt_state[p] = path_stopping_state;
						rpt_upd[p]   = (stop_lim_ff != '0);
					end else if (reconf_req[p]) begin
						nxt_state[p] = path_starting_state;
						rpt_upd[p]   = (start_lim_ff != '0);
					end
				end
				path_stopping_state: begin
					if (mod_reset || stop_done[p]) begin
						nxt_state[p] = path_idle_state;
						chg_set[p]   = (stop_lim_ff != '0) || mod_reset;
						rpt_upd[p]   = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int p = 0; p < NUM_PATHS; p++) begin
				state_ff[p] <= path_idle_state;
			end
		end else begin
			for (int p = 0; p < NUM_PATHS; p++) begin
				state_ff[p] <= nxt_state[p];
			end
		end
	end

	// hide zero-limit transients
	// The reported state skips transient states with a zero limit,
	// so a host polling never sees a state that it was told is instant.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int p = 0; p < NUM_PATHS; p++) begin
				rpt_ff[p] <= path_idle_state;
			end
		end else begin
			for (int p = 0; p < NUM_PATHS; p++) begin
				if (rpt_upd[p]) begin
					rpt_ff[p] <= nxt_state[p];
				end
			end
		end
	end

	// sticky, read clears
	// Set wins over the clear so an event in the read cycle is not lost
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			chg_ff <= '0;
		end else begin
			chg_ff <= (chg_rd ? '0 : chg_ff) | chg_set;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Outputs
	// Electronics handshakes follow the next state of each path
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			path_start_go <= '0;
			path_stop_go  <= '0;
		end else begin
			for (int p = 0; p < NUM_PATHS; p++) begin
				path_start_go[p] <= (nxt_state[p] == path_starting_state);
				path_stop_go[p]  <= (nxt_state[p] == path_stopping_state);
			end
		end
	end

	// tx enabled on entry to live, unless disabled or squelched
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_out_en <= '0;
			rx_out_en <= '0;
		end else begin
			for (int l = 0; l < NUM_LANES; l++) begin
				tx_out_en[l] <= (nxt_state[lane_path_ff[l]] == path_live_state)
					&& !tx_dis_ff[l] && !tx_sq_ff[l];
				rx_out_en[l] <= (nxt_state[lane_path_ff[l]] == path_live_state)
					&& !rx_dis_ff[l];
			end
		end
	end

	// Read data mux; unmapped addresses read zero
	always_comb begin
		nxt_rdata = '0;
		unique case (reg_addr)
			ADDR_POWER_UP:   nxt_rdata = pwr_up_ff;
			ADDR_CTRL: begin
				nxt_rdata[CTRL_FLP_BIT]     = force_lp_ff;
				nxt_rdata[CTRL_PASSIVE_BIT] = passive_ff;
			end
			ADDR_TX_DISABLE: nxt_rdata = tx_dis_ff;
			ADDR_TX_SQUELCH: nxt_rdata = tx_sq_ff;
			ADDR_RX_DISABLE: nxt_rdata = rx_dis_ff;
			ADDR_START_LIM:  nxt_rdata = start_lim_ff;
			ADDR_STOP_LIM:   nxt_rdata = stop_lim_ff;
			ADDR_CHANGED:    nxt_rdata = chg_ff;
			default: ;
		endcase
		for (int l = 0; l < NUM_LANES; l++) begin
			if (reg_addr == ADDR_LANE_CFG + ADDR_W'(l)) begin
				nxt_rdata = {lane_app_ff[l], 1'b0, lane_path_ff[l]};
			end
			if (reg_addr == ADDR_LANE_STATE + ADDR_W'(l / 2)) begin
				nxt_rdata[(l % 2) * 4 +: 4] = passive_ff ? RPT_NONE :
					rpt_code(rpt_ff[lane_path_ff[l]]);
			end
		end
		for (int s = 0; s < ADV_SLOTS; s++) begin
			if (reg_addr == ADDR_ADV_BASE + ADDR_W'(s)) begin
				nxt_rdata = adv_code(s);
			end
		end
	end

	// Read data stands only in the cycle after the read strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= reg_rd ? nxt_rdata : '0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks (path 0 and lane 0 as representatives)

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence seq_host_start;
		state_ff[0] == path_idle_state && !chg_ff[0] && !mod_reset
			&& pup_all[0] ##1 state_ff[0] == path_starting_state;
	endsequence
	sequence seq_quiet_start;
		state_ff[0] == path_starting_state && start_done[0] && !mod_reset
			&& start_lim_ff == '0 && !chg_ff[0];
	endsequence
	chk_idle_to_start: assert property (
		state_ff[0] == path_idle_state && !mod_reset && pup_all[0]
			|=> state_ff[0] == path_starting_state)
		else $error("path did not start on full power-up bits");
	chk_idle_hold: assert property (
		state_ff[0] == path_idle_state && !pup_all[0]
			|=> state_ff[0] == path_idle_state)
		else $error("idle path left without host request");
	chk_reset_idle: assert property (
		state_ff[0] inside {path_starting_state, path_live_state} && mod_reset
			|=> state_ff[0] == path_idle_state && chg_ff[0])
		else $error("reset did not return path to idle with flag");
	chk_live_stop: assert property (
		state_ff[0] == path_live_state && !mod_reset
			&& (force_lp_ff || low_power_req)
			|=> state_ff[0] == path_stopping_state)
		else $error("live path ignored low power request");
	chk_start_noflag: assert property (
		seq_host_start |-> !chg_ff[0])
		else $error("flag set on host-initiated start");
	chk_zero_limit: assert property (
		seq_quiet_start ##1 !chg_rd |=> !chg_ff[0]
			|| state_ff[0] != path_live_state || $past(mod_reset))
		else $error("flag raised for zero-limit start");
	chk_quiet_lane: assert property (
		nxt_state[lane_path_ff[0]] != path_live_state
			|=> !tx_out_en[0] && !rx_out_en[0])
		else $error("lane output active outside live state");
	chk_live_tx: assert property (
		state_ff[lane_path_ff[0]] == path_live_state && !mod_reset
			&& pup_all[lane_path_ff[0]] && !force_lp_ff && !low_power_req
			&& !tx_dis_ff[0] && !tx_sq_ff[0] && !reg_wr
			|=> tx_out_en[0])
		else $error("live lane transmit not enabled");
	chk_flag_sticky: assert property (
		chg_ff[0] && !chg_rd |=> chg_ff[0] [*1])
		else $error("state change flag cleared without read");
	chk_passive_none: assert property (
		passive_ff && reg_rd && reg_addr == ADDR_LANE_STATE
			|=> reg_rdata == '0)
		else $error("passive assembly reported a state");

endmodule

`default_nettype wire

// ==== verif/dpsm_path_model.sv ====
// Behavioural stand-in for the per-path data path electronics.
// Assumes the go outputs stay high for the whole transient state.
`timescale 1ns/1ps
`default_nettype none
module dpsm_path_model
	import dpsm_pkg::*;
#(
	parameter int DLY = 8
) (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// Stall request from the bench
	input  wire logic                 hold,
	// Handshake with the sequencer
	input  wire logic [NUM_PATHS-1:0] path_start_go,
	input  wire logic [NUM_PATHS-1:0] path_stop_go,
	output logic      [NUM_PATHS-1:0] start_done,
	output logic      [NUM_PATHS-1:0] stop_done
);
	logic [7:0] cnt_ff [NUM_PATHS];

	////////////////////////////////////////////////////////////
	// Count cycles spent in a transient state, per path
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int p = 0; p < NUM_PATHS; p++) begin
				cnt_ff[p] <= 8'h00;
			end
		end else begin
			for (int p = 0; p < NUM_PATHS; p++) begin
				if (!(path_start_go[p] || path_stop_go[p])) begin
					cnt_ff[p] <= 8'h00;
				end else if (cnt_ff[p] != 8'hFF) begin
					cnt_ff[p] <= cnt_ff[p] + 8'h01;
				end
			end
		end
	end

	// Done only after the full delay; hold keeps a slow path stalled
	always_comb begin
		for (int p = 0; p < NUM_PATHS; p++) begin
			start_done[p] = path_start_go[p] && !hold && cnt_ff[p] >= DLY;
			stop_done[p]  = path_stop_go[p] && !hold && cnt_ff[p] >= DLY;
		end
	end
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the data path sequencer; the bench is host.
// Assumes the path model answers the done handshakes after a delay.
`timescale 1ns/1ps
`default_nettype none
module tb
	import dpsm_pkg::*;
;
	logic                 core_clk;
	logic                 rst_n;
	logic [ADDR_W-1:0]    reg_addr;
	logic [DATA_W-1:0]    reg_wdata;
	logic                 reg_wr;
	logic                 reg_rd;
	logic [DATA_W-1:0]    reg_rdata;
	logic                 mod_reset;
	logic                 low_power_req;
	logic                 hold;
	logic [NUM_PATHS-1:0] start_done;
	logic [NUM_PATHS-1:0] stop_done;
	logic [NUM_PATHS-1:0] path_start_go;
	logic [NUM_PATHS-1:0] path_stop_go;
	logic [NUM_LANES-1:0] tx_out_en;
	logic [NUM_LANES-1:0] rx_out_en;
	int                   err_count;
	int                   tests_run;
	localparam int TXE = 0;
	localparam int STP = 1;
	localparam int STG = 2;

	// Register defaults after reset: address, expected byte
	typedef struct packed {
		logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] d;
	} dpsm_row_t;
	dpsm_row_t rows [13] = '{
		'{6'h00, 8'h00}, '{6'h05, 8'h00}, '{6'h06, 8'h01},
		'{6'h07, 8'h01}, '{6'h08, 8'h00}, '{6'h10, 8'h10},
		'{6'h17, 8'h10}, '{6'h18, 8'h11}, '{6'h1B, 8'h11},
		'{6'h20, 8'h01}, '{6'h21, 8'hFF}, '{6'h2E, 8'hFF},
		'{6'h3F, 8'h00}};

	////////////////////////////////////////////////////////////
	dpsm_sequencer i_dpsm_sequencer (
		.core_clk      (core_clk),
		.rst_n         (rst_n),
		.reg_addr      (reg_addr),
		.reg_wdata     (reg_wdata),
		.reg_wr        (reg_wr),
		.reg_rd        (reg_rd),
		.reg_rdata     (reg_rdata),
		.mod_reset     (mod_reset),
		.low_power_req (low_power_req),
		.start_done    (start_done),
		.stop_done     (stop_done),
		.path_start_go (path_start_go),
		.path_stop_go  (path_stop_go),
		.tx_out_en     (tx_out_en),
		.rx_out_en     (rx_out_en)
	);
	dpsm_path_model #(.DLY(8)) i_dpsm_path_model (
		.core_clk      (core_clk),
		.rst_n         (rst_n),
		.hold          (hold),
		.path_start_go (path_start_go),
		.path_stop_go  (path_stop_go),
		.start_done    (start_done),
		.stop_done     (stop_done)
	);

	////////////////////////////////////////////////////////////
	// Compare, count and report
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One-cycle write strobe, changed just after the edge
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	// bench polls pins, not registers
	// Poll an output group until it matches; bounded so a hang shows
	task automatic wait_for(input int sel, input logic [7:0] exp);
		logic [7:0] v;
		for (int i = 0; i < 100; i++) begin
			@(posedge core_clk);
			#1;
			v = (sel == TXE) ? tx_out_en :
				(sel == STP) ? path_stop_go : path_start_go;
			if (v === exp)
				break;
		end
		chk(v, exp);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////
	// 50 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Watchdog sized well above the expected run of about 300 cycles
	initial begin
		repeat (8000) @(posedge core_clk);
		err_count++;
		tally_and_finish;
	end

	initial begin
		{rst_n, reg_wr, reg_rd, mod_reset, low_power_req, hold} = '0;
		reg_addr  = '0;
		reg_wdata = '0;
		err_count = 0;
		tests_run = 0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		foreach (rows[i]) rd(rows[i].a, rows[i].d);
		// Slow start: stays quiet and starting until done
		// whole path in one write
		hold <= 1'b1;
		wr(ADDR_POWER_UP, 8'hFF);
		wait_for(STG, 8'h01);
		repeat (20) @(posedge core_clk);
		rd(ADDR_LANE_STATE, 8'h22);
		chk(tx_out_en | rx_out_en, 8'h00);
		rd(ADDR_CHANGED, 8'h00);
		hold <= 1'b0;
		wait_for(TXE, 8'hFF);
		chk(rx_out_en, 8'hFF);
		rd(ADDR_CHANGED, 8'h01);
		rd(ADDR_CHANGED, 8'h00);
		// Live output controls
		wr(ADDR_TX_DISABLE, 8'h0F);
		wr(ADDR_TX_SQUELCH, 8'h10);
		wr(ADDR_RX_DISABLE, 8'h01);
		wait_for(TXE, 8'hE0);
		chk(rx_out_en, 8'hFE);
		wr(ADDR_TX_DISABLE, 8'h00);
		wr(ADDR_TX_SQUELCH, 8'h00);
		wr(ADDR_RX_DISABLE, 8'h00);
		wait_for(TXE, 8'hFF);
		// Reconfiguration of a live path
		wr(ADDR_RECONFIG, 8'h01);
		wait_for(STG, 8'h01);
		chk(tx_out_en, 8'h00);
		rd(ADDR_CHANGED, 8'h00);
		wait_for(TXE, 8'hFF);
		rd(ADDR_CHANGED, 8'h01);
		// Three stop causes: bits cleared, force low power, low power pin
		for (int k = 0; k < 3; k++) begin
			if (k == 1) wr(ADDR_CTRL, 8'h01);
			low_power_req <= (k == 2);
			if (k == 0) wr(ADDR_POWER_UP, 8'h00);
			wait_for(STP, 8'h01);
			chk(tx_out_en | rx_out_en, 8'h00);
			rd(ADDR_CHANGED, 8'h00);
			wr(ADDR_POWER_UP, 8'h00);
			wait_for(STP, 8'h00);
			rd(ADDR_LANE_STATE, 8'h11);
			rd(ADDR_CHANGED, 8'h01);
			wr(ADDR_CTRL, 8'h00);
			low_power_req <= 1'b0;
			wr(ADDR_POWER_UP, 8'hFF);
			wait_for(TXE, 8'hFF);
			rd(ADDR_CHANGED, 8'h01);
		end
		// Module reset from live, then from starting
		mod_reset <= 1'b1;
		wr(ADDR_POWER_UP, 8'h00);
		#1;
		chk(path_start_go | path_stop_go | tx_out_en, 8'h00);
		mod_reset <= 1'b0;
		rd(ADDR_LANE_STATE, 8'h11);
		rd(ADDR_CHANGED, 8'h01);
		hold <= 1'b1;
		wr(ADDR_POWER_UP, 8'hFF);
		wait_for(STG, 8'h01);
		mod_reset <= 1'b1;
		wr(ADDR_POWER_UP, 8'h00);
		mod_reset <= 1'b0;
		hold <= 1'b0;
		wait_for(STG, 8'h00);
		rd(ADDR_CHANGED, 8'h01);
		// Zero limits hide transient states and their flags
		wr(ADDR_START_LIM, 8'h00);
		wr(ADDR_STOP_LIM, 8'h00);
		wr(ADDR_POWER_UP, 8'hFF);
		wait_for(STG, 8'h01);
		rd(ADDR_LANE_STATE, 8'h11);
		wait_for(TXE, 8'hFF);
		rd(ADDR_CHANGED, 8'h00);
		wr(ADDR_POWER_UP, 8'h00);
		wait_for(STP, 8'h01);
		rd(ADDR_LANE_STATE, 8'h33);
		wait_for(STP, 8'h00);
		rd(ADDR_CHANGED, 8'h00);
		// Reset while stopping flags even with a zero stop limit
		wr(ADDR_POWER_UP, 8'hFF);
		wait_for(TXE, 8'hFF);
		hold <= 1'b1;
		wr(ADDR_POWER_UP, 8'h00);
		wait_for(STP, 8'h01);
		mod_reset <= 1'b1;
		wr(ADDR_POWER_UP, 8'h00);
		mod_reset <= 1'b0;
		hold <= 1'b0;
		wait_for(STP, 8'h00);
		rd(ADDR_CHANGED, 8'h01);
		wr(ADDR_START_LIM, 8'h01);
		wr(ADDR_STOP_LIM, 8'h01);
		// Two paths: lanes 4-7 form path 1
		for (int l = 4; l < 8; l++) wr(ADDR_LANE_CFG + 6'(l), 8'h11);
		wr(ADDR_POWER_UP, 8'h0F);
		wait_for(TXE, 8'h0F);
		wr(ADDR_POWER_UP, 8'h1F);
		repeat (4) @(posedge core_clk);
		#1;
		chk(path_start_go, 8'h00);
		wr(ADDR_POWER_UP, 8'hFF);
		wait_for(STG, 8'h02);
		chk(tx_out_en, 8'h0F);
		wait_for(TXE, 8'hFF);
		rd(ADDR_LANE_STATE + 6'h02, 8'h33);
		wr(ADDR_POWER_UP, 8'hF0);
		wait_for(STP, 8'h01);
		chk(tx_out_en, 8'hF0);
		wait_for(STP, 8'h00);
		rd(ADDR_LANE_STATE, 8'h11);
		rd(ADDR_LANE_STATE + 6'h03, 8'h33);
		rd(ADDR_CHANGED, 8'h03);
		// Reconfiguration of an idle path is ignored
		wr(ADDR_RECONFIG, 8'h01);
		repeat (3) @(posedge core_clk);
		#1;
		chk(path_start_go, 8'h00);
		// Passive copper reports no state
		wr(ADDR_CTRL, 8'h02);
		rd(ADDR_LANE_STATE + 6'h02, 8'h00);
		rd(ADDR_LANE_STATE, 8'h00);
		wr(ADDR_CTRL, 8'h00);
		// Asynchronous reset in mid-run with path 1 live
		rst_n <= 1'b0;
		#1;
		chk(tx_out_en | rx_out_en | path_start_go, 8'h00);
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(ADDR_LANE_STATE + 6'h02, 8'h11);
		rd(ADDR_LANE_CFG + 6'h07, 8'h10);
		tally_and_finish;
	end
endmodule
`default_nettype wire
